/* File: logic/smhg_pkg.sv */
// Constants and types for the stacked flash/SRAM host controller.
// Assumes a 250 MHz sys_clk; pin timings are counted in its cycles.
//
// What the datasheet requires
// (RULE1) SRAM writes only while primary select low, secondary high, strobe low together.
// (RULE2) Write starts at last qualifying assertion, ends at first deassertion.
// (RULE3) Host never selects SRAM while flash select is low.
// (RULE4) Host holds flash reset low at power-up, over 100 ns after supply good.
// (RULE5) Flash refuses writes and erases while its reset input is low.
// (RULE6) Write-protect low locks the flash boot blocks.
// (RULE7) Write-protect does not lock parameter or main blocks.
// (RULE8) Program supply below lockout level disables all flash writes.
// (RULE9) Host programs 0 only at bits changing 1 to 0, else 1. Code: SMHG_OP_FLASH_PG only; SMHG_OP_FLASH_WR drives req_wdata as is.
// (RULE10) Host issues no erase, write or lock command while program supply invalid.
// (RULE11) Lower lane enable gates bits 0-7, upper gates 8-15; high means idle.
package smhg_pkg;

  localparam int          CLK_MHZ        = 250;
  localparam int          RST_HOLD_NS    = 100;
  // Strictly longer than the hold time, rounded up
  localparam int          RST_HOLD_CYC   = (RST_HOLD_NS * CLK_MHZ) / 1000 + 1;
  localparam int          SRAM_WP_NS     = 60;
  localparam int          SRAM_WP_CYC    = (SRAM_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int          FLASH_WP_NS    = 60;
  localparam int          FLASH_WP_CYC   = (FLASH_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int          RD_NS          = 90;
  localparam int          RD_CYC         = (RD_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W          = 6;
  localparam int          ADDR_W         = 20;
  localparam int          DATA_W         = 16;
  localparam int          BOOT_BLK_WORDS = 4096;
  localparam int          BOOT_BLKS      = 2;
  localparam logic [ADDR_W-1:0] BOOT_END = 20'h02000;

  // Request kinds
  typedef enum logic [2:0] {
    SMHG_OP_SRAM_RD  = 3'h0,
    SMHG_OP_SRAM_WR  = 3'h1,
    SMHG_OP_FLASH_RD = 3'h2,
    SMHG_OP_FLASH_WR = 3'h3,
    SMHG_OP_FLASH_PG = 3'h4
  } smhg_op_t;

  // Result codes
  typedef enum logic [1:0] {
    SMHG_RES_OK      = 2'h0,
    SMHG_RES_LOCKED  = 2'h1,
    SMHG_RES_NOSUPP  = 2'h2,
    SMHG_RES_INRESET = 2'h3
  } smhg_res_t;

  // Gray-coded along idle -> setup -> pulse -> hold
  typedef enum logic [2:0] {
    SMHG_ST_PWRUP = 3'b000,
    SMHG_ST_IDLE  = 3'b001,
    SMHG_ST_SETUP = 3'b011,
    SMHG_ST_PULSE = 3'b010,
    SMHG_ST_HOLD  = 3'b110,
    SMHG_ST_DONE  = 3'b111
  } smhg_state_t;

  // Word to program so only 1->0 bits carry 0
  function automatic logic [DATA_W-1:0] prog_word(input logic [DATA_W-1:0] cur,
                                                  input logic [DATA_W-1:0] want);
    prog_word = ~(cur & ~want);
  endfunction : prog_word

  function automatic logic in_boot(input logic [ADDR_W-1:0] a);
    in_boot = (a < BOOT_END);
  endfunction : in_boot

endpackage : smhg_pkg

/* File: logic/smhg_sync.sv */
// Two-flop synchroniser for a vector of pin levels.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module smhg_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : smhg_sync
`default_nettype wire

/* File: logic/smhg_host.sv */
// Host controller for a stacked flash plus SRAM on a shared bus.
// Assumes one request at a time on the user port; supply-good from a monitor pin.
`timescale 1ns/1ps
`default_nettype none
module smhg_host
  import smhg_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Supply monitor pins
  input  wire logic              flash_supply_good,
  input  wire logic              program_supply_ok,
  // User request port
  input  wire logic              req_valid,
  input  wire smhg_op_t          req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lane_en,
  input  wire logic              boot_protect,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output smhg_res_t              rsp_code,
  output logic [DATA_W-1:0]      rsp_rdata,
  // Device pins
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0]      mem_dq_out,
  output logic                   mem_dq_oe,
  output logic                   flash_select_n,
  output logic                   flash_write_n,
  output logic                   flash_read_n,
  output logic                   flash_powerdown_reset_n,
  output logic                   flash_write_protect_n,
  output logic                   sram_primary_select_n,
  output logic                   sram_secondary_select,
  output logic                   sram_write_n,
  output logic                   sram_read_n,
  output logic                   sram_upper_lane_enable_n,
  output logic                   sram_lower_lane_enable_n
);
  smhg_state_t       st_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [1:0]        pins_s;
  logic              vcc_ok;
  logic              vpp_ok;
  smhg_op_t          op_q;
  logic              wr_q;
  logic [DATA_W-1:0] dq_in_s;

  smhg_sync #(.W(2)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({flash_supply_good, program_supply_ok}),
    .sync_out (pins_s)
  );
  assign vcc_ok = pins_s[1];
  assign vpp_ok = pins_s[0];

  smhg_sync #(.W(DATA_W)) u_dq_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (mem_dq_in),
    .sync_out (dq_in_s)
  );

  // Request checks
  function automatic smhg_res_t check(input smhg_op_t op, input logic [ADDR_W-1:0] a,
                                      input logic prot, input logic vpp);
    check = SMHG_RES_OK;
    if (op == SMHG_OP_FLASH_WR || op == SMHG_OP_FLASH_PG) begin
      if (!vpp)
        check = SMHG_RES_NOSUPP;            // [RULE10] [RULE8]
      else if (prot && in_boot(a))
        check = SMHG_RES_LOCKED;            // [RULE6] [RULE7]
    end
  endfunction : check

  // Sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= SMHG_ST_PWRUP;
      cnt_q     <= '0;
      op_q      <= SMHG_OP_SRAM_RD;
      wr_q      <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_code  <= SMHG_RES_OK;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st_q)
        SMHG_ST_PWRUP: begin
          // Hold reset until supply good plus a strict margin
          if (!vcc_ok)
            cnt_q <= '0;                    // [RULE4]
          else if (cnt_q == CNT_W'(RST_HOLD_CYC)) begin
            st_q      <= SMHG_ST_IDLE;
            req_ready <= 1'b1;
          end else
            cnt_q <= cnt_q + 1'b1;          // [RULE4]
        end
        SMHG_ST_IDLE: begin
          if (!vcc_ok) begin
            st_q      <= SMHG_ST_PWRUP;     // [RULE5]
            cnt_q     <= '0;
            req_ready <= 1'b0;
          end else if (req_valid) begin
            req_ready <= 1'b0;
            if (check(req_op, req_addr, boot_protect, vpp_ok) != SMHG_RES_OK) begin
              rsp_valid <= 1'b1;
              rsp_code  <= check(req_op, req_addr, boot_protect, vpp_ok);
              st_q      <= SMHG_ST_DONE;
            end else begin
              op_q  <= req_op;
              wr_q  <= (req_op == SMHG_OP_SRAM_WR) || (req_op == SMHG_OP_FLASH_WR)
                       || (req_op == SMHG_OP_FLASH_PG);
              st_q  <= SMHG_ST_SETUP;
              cnt_q <= '0;
            end
          end
        end
        SMHG_ST_SETUP: begin
          st_q  <= SMHG_ST_PULSE;
          cnt_q <= '0;
        end
        SMHG_ST_PULSE: begin
          if ((op_q == SMHG_OP_SRAM_WR && cnt_q == CNT_W'(SRAM_WP_CYC - 1)) ||
              (wr_q && op_q != SMHG_OP_SRAM_WR && cnt_q == CNT_W'(FLASH_WP_CYC - 1)) ||
              (!wr_q && cnt_q == CNT_W'(RD_CYC + 1))) begin
            st_q      <= SMHG_ST_HOLD;      // [RULE2]
            rsp_rdata <= dq_in_s;
          end else
            cnt_q <= cnt_q + 1'b1;
        end
        SMHG_ST_HOLD: begin
          rsp_valid <= 1'b1;
          rsp_code  <= SMHG_RES_OK;
          st_q      <= SMHG_ST_DONE;
        end
        SMHG_ST_DONE: begin
          st_q      <= SMHG_ST_IDLE;
          req_ready <= 1'b1;
        end
        default: begin
          st_q      <= SMHG_ST_PWRUP;
          cnt_q     <= '0;
          req_ready <= 1'b0;
        end
      endcase
    end
  end

  // Flash reset pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      flash_powerdown_reset_n <= 1'b0;      // [RULE4]
    else
      flash_powerdown_reset_n <= (st_q != SMHG_ST_PWRUP) && vcc_ok; // [RULE4] [RULE5]
  end

  // Protect pin follows the user's boot-lock wish
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      flash_write_protect_n <= 1'b0;
    else
      flash_write_protect_n <= !boot_protect; // [RULE6]
  end

  // Address, data and selects
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr                 <= '0;
      mem_dq_out               <= '0;
      mem_dq_oe                <= 1'b0;
      flash_select_n           <= 1'b1;
      sram_primary_select_n    <= 1'b1;
      sram_secondary_select    <= 1'b0;
      sram_upper_lane_enable_n <= 1'b1;
      sram_lower_lane_enable_n <= 1'b1;
    end else if (st_q == SMHG_ST_IDLE && req_valid && vcc_ok &&
                 check(req_op, req_addr, boot_protect, vpp_ok) == SMHG_RES_OK) begin
      mem_addr <= req_addr;
      mem_dq_out <= (req_op == SMHG_OP_FLASH_PG) ? prog_word(rsp_rdata, req_wdata)
                                                : req_wdata; // [RULE9]
      mem_dq_oe <= (req_op == SMHG_OP_SRAM_WR) || (req_op == SMHG_OP_FLASH_WR)
                   || (req_op == SMHG_OP_FLASH_PG);
      // Only one memory selected at a time
      flash_select_n        <= (req_op == SMHG_OP_SRAM_RD) || (req_op == SMHG_OP_SRAM_WR); // [RULE3]
      sram_primary_select_n <= !((req_op == SMHG_OP_SRAM_RD) || (req_op == SMHG_OP_SRAM_WR));
      sram_secondary_select <= (req_op == SMHG_OP_SRAM_RD) || (req_op == SMHG_OP_SRAM_WR); // [RULE3]
      sram_lower_lane_enable_n <= !req_lane_en[0]; // [RULE11]
      sram_upper_lane_enable_n <= !req_lane_en[1]; // [RULE11]
    end else if (st_q == SMHG_ST_HOLD || st_q == SMHG_ST_DONE) begin
      mem_dq_oe                <= 1'b0;
      flash_select_n           <= 1'b1;
      sram_primary_select_n    <= 1'b1;
      sram_secondary_select    <= 1'b0;
      sram_upper_lane_enable_n <= 1'b1;
      sram_lower_lane_enable_n <= 1'b1;
    end
  end

  // Strobes: asserted inside the select window; write strobes released first, read strobes with the selects
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_write_n <= 1'b1;
      flash_read_n  <= 1'b1;
      sram_write_n  <= 1'b1;
      sram_read_n   <= 1'b1;
    end else begin
      flash_write_n <= !(st_q == SMHG_ST_SETUP && wr_q && op_q != SMHG_OP_SRAM_WR
                         || st_q == SMHG_ST_PULSE && wr_q && op_q != SMHG_OP_SRAM_WR
                            && cnt_q != CNT_W'(FLASH_WP_CYC - 1));
      sram_write_n  <= !(st_q == SMHG_ST_SETUP && op_q == SMHG_OP_SRAM_WR
                         || st_q == SMHG_ST_PULSE && op_q == SMHG_OP_SRAM_WR
                            && cnt_q != CNT_W'(SRAM_WP_CYC - 1)); // [RULE1] [RULE2]
      flash_read_n  <= !((st_q == SMHG_ST_SETUP || st_q == SMHG_ST_PULSE)
                         && op_q == SMHG_OP_FLASH_RD);
      sram_read_n   <= !((st_q == SMHG_ST_SETUP || st_q == SMHG_ST_PULSE)
                         && op_q == SMHG_OP_SRAM_RD);
    end
  end
endmodule : smhg_host
`default_nettype wire

/* File: tb/smhg_host_monitor.sv */
// Checker for the stacked memory host controller.
// Bound onto smhg_host; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module smhg_host_monitor
  import smhg_pkg::*;
(
  // Clock and reset
  input wire logic      sys_clk,
  input wire logic      rst_n,
  // Inputs
  input wire logic      flash_supply_good,
  input wire logic      program_supply_ok,
  input wire logic      req_valid,
  input wire smhg_op_t  req_op,
  input wire logic      boot_protect,
  // Outputs
  input wire logic      req_ready,
  input wire logic      rsp_valid,
  input wire smhg_res_t rsp_code,
  input wire logic      flash_select_n,
  input wire logic      flash_write_n,
  input wire logic      flash_powerdown_reset_n,
  input wire logic      flash_write_protect_n,
  input wire logic      sram_primary_select_n,
  input wire logic      sram_secondary_select,
  input wire logic      flash_read_n,
  input wire logic      sram_write_n,
  input wire logic      sram_read_n,
  input wire logic      mem_dq_oe
);
  logic [7:0] good_q;
  logic       fwr;
  assign fwr = req_valid && req_ready && req_op inside {SMHG_OP_FLASH_WR, SMHG_OP_FLASH_PG};
  // Cycles the flash supply has been good
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) good_q <= 8'h00;
    else if (!flash_supply_good) good_q <= 8'h00;
    else if (good_q != 8'hff) good_q <= good_q + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  bus_excl_a: assert property (!(!sram_primary_select_n && sram_secondary_select
    && !flash_select_n)) else $error("flash and sram selected together");
  reset_hold_a: assert property ($rose(flash_powerdown_reset_n) |-> good_q > 8'd25)
    else $error("flash reset released too early");
  vpp_refuse_a: assert property (fwr && !program_supply_ok && !$past(program_supply_ok, 4)
    |-> ##1 rsp_valid && rsp_code == SMHG_RES_NOSUPP && flash_write_n)
    else $error("flash write taken with program supply low");
  vpp_nowrite_a: assert property ($fell(flash_write_n) |-> $past(program_supply_ok, 4))
    else $error("flash strobe with program supply low");
  boot_lock_a: assert property (boot_protect |=> !flash_write_protect_n)
    else $error("boot protect not driven");
  sram_strobe_a: assert property (!sram_write_n |-> !sram_primary_select_n
    && sram_secondary_select) else $error("sram strobe outside select window");
  write_end_a: assert property ($rose(sram_write_n) |-> !sram_primary_select_n
    && sram_secondary_select) else $error("sram write not ended by strobe");
  dq_turn_a: assert property (!mem_dq_oe || (flash_read_n && sram_read_n))
    else $error("host drives data during a read");
endmodule : smhg_host_monitor
bind smhg_host smhg_host_monitor u_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .flash_supply_good(flash_supply_good),
  .program_supply_ok(program_supply_ok), .req_valid(req_valid), .req_op(req_op),
  .boot_protect(boot_protect), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_code(rsp_code), .flash_select_n(flash_select_n), .flash_write_n(flash_write_n),
  .flash_powerdown_reset_n(flash_powerdown_reset_n),
  .flash_write_protect_n(flash_write_protect_n),
  .sram_primary_select_n(sram_primary_select_n), .sram_secondary_select(sram_secondary_select),
  .flash_read_n(flash_read_n), .sram_write_n(sram_write_n), .sram_read_n(sram_read_n),
  .mem_dq_oe(mem_dq_oe)
);
`default_nettype wire

/* File: tb/smhg_dev_model.sv */
// Behavioural stacked flash plus SRAM on the shared bus.
// Assumes the host holds pins steady around each strobe; only low address bits decode.
`timescale 1ns/1ps
`default_nettype none
module smhg_dev_model
  import smhg_pkg::*;
(
  // Clock for the bus keeper
  input wire logic               sys_clk,
  // Shared bus
  input wire logic [ADDR_W-1:0]  mem_addr,
  input wire logic [DATA_W-1:0]  mem_dq_out,
  output logic [DATA_W-1:0]      mem_dq_in,
  // Flash pins
  input wire logic               flash_select_n,
  input wire logic               flash_write_n,
  input wire logic               flash_read_n,
  input wire logic               flash_powerdown_reset_n,
  input wire logic               flash_write_protect_n,
  input wire logic               program_supply_ok,
  // SRAM pins
  input wire logic               sram_primary_select_n,
  input wire logic               sram_secondary_select,
  input wire logic               sram_write_n,
  input wire logic               sram_read_n,
  input wire logic               sram_upper_lane_enable_n,
  input wire logic               sram_lower_lane_enable_n,
  // Last word accepted for programming
  output logic [DATA_W-1:0]      last_prog
);
  logic [DATA_W-1:0] fl [256];
  logic [DATA_W-1:0] sr [256];
  logic [DATA_W-1:0] last_q;
  logic              fdrv, sdrv, swin;
  logic [7:0]        a;
  initial begin
    foreach (fl[i]) fl[i] = 16'hffff;
    foreach (sr[i]) sr[i] = 16'h0000;
    last_q = 16'h0000;
    last_prog = 16'h0000;
  end
  assign a = mem_addr[7:0];
  assign swin = !sram_primary_select_n && sram_secondary_select && !sram_write_n;
  // Word lands when the first qualifier drops
  always @(negedge swin) begin
    if (!sram_lower_lane_enable_n) sr[a][7:0] = mem_dq_out[7:0];
    if (!sram_upper_lane_enable_n) sr[a][15:8] = mem_dq_out[15:8];
  end
  always @(posedge flash_write_n) begin
    if (!flash_select_n && flash_powerdown_reset_n && program_supply_ok
        && !(mem_addr < BOOT_END && !flash_write_protect_n)) begin
      last_prog = mem_dq_out;
      fl[a] = fl[a] & mem_dq_out;
    end
  end
  assign fdrv = !flash_select_n && !flash_read_n && flash_powerdown_reset_n;
  assign sdrv = !sram_primary_select_n && sram_secondary_select && !sram_read_n;
  // Released bus shows the inverse of the last driven word
  always @(posedge sys_clk) if (fdrv || sdrv) last_q <= mem_dq_in;
  assign mem_dq_in = fdrv ? fl[a] : !sdrv ? ~last_q :
    {sram_upper_lane_enable_n ? ~last_q[15:8] : sr[a][15:8],
     sram_lower_lane_enable_n ? ~last_q[7:0] : sr[a][7:0]};
endmodule : smhg_dev_model
`default_nettype wire

/* File: tb/smhg_host_test.sv */
// Testbench for the stacked memory host controller.
// Assumes the device model answers on the pins; responses checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module smhg_host_test
  import smhg_pkg::*;
();
  logic              sys_clk, rst_n, flash_supply_good, program_supply_ok, req_valid;
  logic              boot_protect, req_ready, rsp_valid, flash_select_n, flash_write_n;
  logic              flash_read_n, flash_powerdown_reset_n, flash_write_protect_n;
  logic              sram_primary_select_n, sram_secondary_select, sram_write_n, sram_read_n;
  logic              sram_upper_lane_enable_n, sram_lower_lane_enable_n;
  smhg_op_t          req_op;
  smhg_res_t         rsp_code;
  logic [ADDR_W-1:0] req_addr, mem_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_dq_in, mem_dq_out, last_prog, d1, d2;
  logic [1:0]        req_lane_en;
  logic [18:0]       exp_q [$];
  logic [18:0]       e, wr_ok;
  int                err_count, tests_run;
  smhg_host DUT (.sys_clk, .rst_n, .flash_supply_good, .program_supply_ok, .req_valid, .req_op,
    .req_addr, .req_wdata, .req_lane_en, .boot_protect, .req_ready, .rsp_valid, .rsp_code,
    .rsp_rdata, .mem_addr, .mem_dq_in, .mem_dq_out, .mem_dq_oe(), .flash_select_n,
    .flash_write_n, .flash_read_n, .flash_powerdown_reset_n, .flash_write_protect_n,
    .sram_primary_select_n, .sram_secondary_select, .sram_write_n, .sram_read_n,
    .sram_upper_lane_enable_n, .sram_lower_lane_enable_n);
  smhg_dev_model u_dev (.sys_clk, .mem_addr, .mem_dq_out, .mem_dq_in, .flash_select_n,
    .flash_write_n, .flash_read_n, .flash_powerdown_reset_n, .flash_write_protect_n,
    .program_supply_ok, .sram_primary_select_n, .sram_secondary_select, .sram_write_n,
    .sram_read_n, .sram_upper_lane_enable_n, .sram_lower_lane_enable_n, .last_prog);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check_code(input string nm, input smhg_res_t ex, input smhg_res_t got);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %s exp %0h got %0h", nm, ex, got);
    end
  endtask : check_code
  task automatic check_data(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask : check_data
  task automatic hang();
    err_count++;
    $display("[ERR] wait exp done got timeout");
    print_verdict();
  endtask : hang
  task automatic do_req(input smhg_op_t op, input logic [19:0] ad, input logic [15:0] wd,
                        input logic [1:0] ln, input logic [18:0] ex);
    int n;
    @(posedge sys_clk);
    exp_q.push_back(ex);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= ad;
    req_wdata <= wd;
    req_lane_en <= ln;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    if (n >= 300) hang();
    req_valid <= 1'b0;
  endtask : do_req
  task automatic idle();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || req_ready !== 1'b1) && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 300) hang();
    repeat (4) @(posedge sys_clk);
  endtask : idle
  // Each response is matched against the oldest note
  always @(posedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("[ERR] rsp_valid exp 0 got 1");
      end else begin
        e = exp_q.pop_front();
        check_code("rsp_code", smhg_res_t'(e[17:16]), rsp_code);
        if (e[18]) check_data("rsp_rdata", e[15:0], rsp_rdata);
      end
    end
  end
  initial begin
    void'($urandom(32'hcd89));
    {rst_n, flash_supply_good, req_valid, boot_protect, req_lane_en} = '0;
    program_supply_ok = 1'b1;
    req_op = SMHG_OP_SRAM_RD;
    {req_addr, req_wdata} = '0;
    wr_ok = {1'b0, SMHG_RES_OK, 16'h0000};
    d1 = 16'($urandom);
    d2 = 16'($urandom);
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    flash_supply_good <= 1'b1;
    idle();
    do_req(SMHG_OP_SRAM_WR, 20'h00005, d1, 2'b11, wr_ok);
    do_req(SMHG_OP_SRAM_WR, 20'h00005, d2, 2'b01, wr_ok);
    do_req(SMHG_OP_SRAM_RD, 20'h00005, 16'h0, 2'b11, {1'b1, SMHG_RES_OK, d1[15:8], d2[7:0]});
    do_req(SMHG_OP_FLASH_WR, 20'h04020, 16'hbdbd, 2'b11, wr_ok);
    do_req(SMHG_OP_FLASH_RD, 20'h04020, 16'h0, 2'b11, {1'b1, SMHG_RES_OK, 16'hbdbd});
    do_req(SMHG_OP_FLASH_PG, 20'h04020, 16'hadbc, 2'b11, wr_ok);
    idle();
    check_data("prog_word", 16'heffe, last_prog);
    do_req(SMHG_OP_FLASH_RD, 20'h04020, 16'h0, 2'b11, {1'b1, SMHG_RES_OK, 16'hadbc});
    idle();
    program_supply_ok <= 1'b0;
    repeat (4) @(posedge sys_clk);
    do_req(SMHG_OP_FLASH_WR, 20'h04040, d1, 2'b11, {1'b0, SMHG_RES_NOSUPP, 16'h0});
    do_req(SMHG_OP_FLASH_PG, 20'h04040, d2, 2'b11, {1'b0, SMHG_RES_NOSUPP, 16'h0});
    idle();
    program_supply_ok <= 1'b1;
    boot_protect <= 1'b1;
    repeat (4) @(posedge sys_clk);
    do_req(SMHG_OP_FLASH_WR, 20'h00010, 16'h0, 2'b11, {1'b0, SMHG_RES_LOCKED, 16'h0});
    do_req(SMHG_OP_FLASH_WR, 20'h04030, d1, 2'b11, wr_ok);
    do_req(SMHG_OP_FLASH_RD, 20'h00010, 16'h0, 2'b11, {1'b1, SMHG_RES_OK, 16'hffff});
    do_req(SMHG_OP_FLASH_RD, 20'h04030, 16'h0, 2'b11, {1'b1, SMHG_RES_OK, d1});
    idle();
    print_verdict();
  end
endmodule : smhg_host_test
`default_nettype wire
